/* hdl/dcs_pkg.sv */
// dcs_pkg: offsets, fields, reset values and types of the channel control
// assumes: included before the buffer, watermark and top modules
package dcs_pkg;

    // ----
    // register map
    // ----
    localparam logic [11:0] CTRL_STATUS_OFS  = 12'h400;
    localparam logic [31:0] CTRL_STATUS_RST  = 32'h00000000;

    // ----
    // field positions in the control and status word
    // ----
    localparam int BIT_LAUNCH      = 31;
    localparam int BIT_RST_REQ     = 30;
    localparam int BIT_RUNNING     = 23;
    localparam int BIT_RST_FLAG    = 22;
    localparam int BIT_FINISHED    = 21;
    localparam int BIT_PCI_ERR     = 20;
    localparam int BIT_LOCAL_ERR   = 19;
    localparam int BIT_CMD_SEL     = 18;
    localparam int POS_WATERMARK   = 12;
    localparam int POS_XFER_CODE   = 8;
    localparam int BIT_CODE_EN     = 7;
    localparam int BIT_CHAIN       = 6;
    localparam int BIT_ENGINE      = 5;
    localparam int BIT_DIR         = 4;
    localparam int BIT_PROTO       = 3;
    localparam int BIT_OWN_TERM    = 2;
    localparam int BIT_SLAVE_TERM  = 1;
    localparam int BIT_LOCAL_PORT_WIDTH      = 0;

    // ----
    // counts and encodings
    // ----
    localparam logic [21:0] MIN_COUNT_WORDS = 22'h000010; // least programmed count field
    localparam logic [21:0] WORD_STEP       = 22'h000001; // counter drops by one for each 32-bit word
    localparam logic [3:0]  PCI_CMD_MEM_RD  = 4'h6;
    localparam logic [3:0]  PCI_CMD_MEM_WR  = 4'h7;
    localparam logic [3:0]  PCI_CMD_RD_LINE = 4'hE;
    localparam logic [3:0]  PCI_CMD_WR_INV  = 4'hF;
    localparam int          BUF_WIDTH       = 32;

    // ----
    // types
    // ----
    typedef enum logic [1:0] {
        DCS_IDLE,
        DCS_RUN,
        DCS_FINISH
    } dcs_state_t;

    // writable control fields
    typedef struct packed {
        logic       cmd_sel;
        logic [3:0] fifo_watermark;
        logic [3:0] transfer_code_match;
        logic       transfer_code_decode_enable;
        logic       chain;
        logic       engine_dma;
        logic       dir_to_pci;
        logic       peripheral_protocol_select;
        logic       own_termination_speed;
        logic       slave_termination_speed;
        logic       local_port_width;
    } dcs_ctrl_t;

    // sticky event flags
    typedef struct packed {
        logic reset_occurred_flag;
        logic finished;
        logic pci_error_flag;
        logic local_bus_error_flag;
    } dcs_flags_t;

    // register access from either bus
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wdata;
    } dcs_reg_req_t;

    // transfer-mode outputs steering the datapath
    typedef struct packed {
        logic [3:0] pci_cmd;
        logic       linked_list;
        logic       stand_alone;
        logic       dir_to_pci;
        logic       proto_second;
        logic       fast_own_term;
        logic       fast_slave_term;
        logic       port_16bit;
    } dcs_mode_t;

endpackage

/* hdl/dcs_buf2.sv */
// dcs_buf2: two-entry valid/ready buffer in the channel data path
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module dcs_buf2 #(
    parameter int WIDTH = 32
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  rd_ptr;
        logic                  wr_ptr;
        logic [1:0]            count;
    } dcs_buf_state_t;

    dcs_buf_state_t st_r;
    dcs_buf_state_t st_nxt;
    logic           push;
    logic           pop;

    // ----
    // handshake
    // ----
    assign in_ready  = (st_r.count != 2'd2);
    assign out_valid = (st_r.count != 2'd0);
    assign out_data  = st_r.mem[st_r.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // next state of pointers and storage
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr_ptr] = in_data;
            st_nxt.wr_ptr = ~st_r.wr_ptr;
        end
        if (pop) begin
            st_nxt.rd_ptr = ~st_r.rd_ptr;
        end
        st_nxt.count = st_r.count + {1'b0, push} - {1'b0, pop};
        if (flush) begin
            st_nxt.rd_ptr = 1'b0;
            st_nxt.wr_ptr = 1'b0;
            st_nxt.count  = 2'd0;
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

`default_nettype wire

/* hdl/dcs_watermark.sv */
// dcs_watermark: decides when queued inbound bytes warrant a pci bus request
// assumes: byte counts and settings are stable register values
`timescale 1ns/1ps
`default_nettype none

module dcs_watermark #(
    parameter int LEVEL_W = 9
) (
    input  wire logic [3:0]         fifo_watermark,
    input  wire logic [1:0]         cache_line_setting,
    input  wire logic [LEVEL_W-1:0] queued_bytes,
    output logic                    request_bus
);

    logic [LEVEL_W-1:0] threshold;

    // 16 x bytes, or the cache line size when the field is zero
    always_comb begin
        if (fifo_watermark != 4'h0) begin
            threshold = LEVEL_W'({fifo_watermark, 4'h0});
        end else begin
            threshold = LEVEL_W'({cache_line_setting, 4'h0}) + LEVEL_W'(16);
        end
        request_bus = (queued_bytes >= threshold);
    end

endmodule

`default_nettype wire

/* hdl/dcs_channel_ctrl.sv */
// dcs_channel_ctrl: control and status word of the single dma channel
// assumes: register accesses from the pci side and the local side arrive as
// one-cycle strobes; transfer events come from the channel datapath

`timescale 1ns/1ps
`default_nettype none

// Contract
// - launch bit starts transfers, reads zero
// - reset request while running resets, flags
// - reset request ignored when channel idle
// - running bit shows transfer in progress
// - count expiry or done sets finished, idles
// - pci error sets flag, write one clears
// - local error sets flag, write one clears
// - command bit picks plain or line commands
// - transfer code field qualifies acknowledge
// - code enable gates decode, peripheral only
// - chaining bit picks direct or linked list
// - engine bit picks peripheral or stand-alone
// - direction bit picks pci-to-local or reverse
// - protocol bit picks handshake family
// - own termination speed, dual-address first family
// - slave termination speed, single-address first family
// - port width bit selects 32 or 16
// - four events offered for interrupt routing
// - count below sixteen bytes blocks start; here a count below 16 words blocks it
// - counter drops four bytes per pci word; here it drops by one per word
module dcs_channel_ctrl #(
    parameter int COUNT_W = 22,
    parameter int LEVEL_W = 9
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,

    // registers
    input  wire dcs_pkg::dcs_reg_req_t    pci_req,
    input  wire dcs_pkg::dcs_reg_req_t    local_req,
    output logic [31:0]                   pci_rdata,
    output logic [31:0]                   local_rdata,

    // events
    input  wire logic [COUNT_W-1:0]       count_load,
    input  wire logic                     count_load_en,
    input  wire logic                     pci_word_done,
    input  wire logic                     peripheral_done,
    input  wire logic                     pci_error,
    input  wire logic                     local_bus_error,

    // handshake
    input  wire logic [3:0]               transfer_code_in,
    input  wire logic                     peripheral_acknowledge,
    input  wire logic                     dual_address,
    input  wire logic [1:0]               cache_line_setting,
    input  wire logic [LEVEL_W-1:0]       queued_bytes,

    // buffer
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [31:0]              in_data,
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [31:0]                   out_data,

    // status
    output logic                          transfer_running,
    output logic                          ack_qualified,
    output logic                          pci_bus_request,
    output logic                          fast_termination,
    output logic                          slave_fast_termination,
    output dcs_pkg::dcs_mode_t            mode,
    output dcs_pkg::dcs_flags_t           event_flags,
    output logic [COUNT_W-1:0]            remaining_byte_counter
);

    // ----
    // state
    // ----
    typedef struct packed {
        dcs_pkg::dcs_state_t  fsm;
        dcs_pkg::dcs_ctrl_t   ctrl;
        dcs_pkg::dcs_flags_t  flags;
        logic [COUNT_W-1:0]   count;

        logic [31:0]          pci_rdata;
        logic [31:0]          local_rdata;
        logic                 ack_q;
        logic                 req_q;
        logic                 fast_q;
        logic                 sfast_q;

        dcs_pkg::dcs_mode_t   mode;
    } dcs_top_state_t;

    dcs_top_state_t st_r;
    dcs_top_state_t st_nxt;

    logic           wm_request;
    logic           buf_in_ready;
    logic           buf_out_valid;
    logic [31:0]    buf_out_data;

    logic           flush;

    // ----
    // helpers
    // ----
    // decode a register write at the control word
    function automatic logic hits(input dcs_pkg::dcs_reg_req_t r);
        hits = r.wr && (r.addr == dcs_pkg::CTRL_STATUS_OFS);
    endfunction

    // assemble the readable word; launch and reset request read as zero
    function automatic logic [31:0] pack_word(input dcs_top_state_t s);
        logic [31:0] w;
        w = 32'h00000000;

        w[dcs_pkg::BIT_RUNNING]    = (s.fsm == dcs_pkg::DCS_RUN);
        w[dcs_pkg::BIT_RST_FLAG]   = s.flags.reset_occurred_flag;
        w[dcs_pkg::BIT_FINISHED]   = s.flags.finished;
        w[dcs_pkg::BIT_PCI_ERR]    = s.flags.pci_error_flag;
        w[dcs_pkg::BIT_LOCAL_ERR]  = s.flags.local_bus_error_flag;

        w[dcs_pkg::BIT_CMD_SEL]    = s.ctrl.cmd_sel;
        w[dcs_pkg::POS_WATERMARK +: 4] = s.ctrl.fifo_watermark;
        w[dcs_pkg::POS_XFER_CODE +: 4] = s.ctrl.transfer_code_match;
        w[dcs_pkg::BIT_CODE_EN]    = s.ctrl.transfer_code_decode_enable;
        w[dcs_pkg::BIT_CHAIN]      = s.ctrl.chain;
        w[dcs_pkg::BIT_ENGINE]     = s.ctrl.engine_dma;
        w[dcs_pkg::BIT_DIR]        = s.ctrl.dir_to_pci;
        w[dcs_pkg::BIT_PROTO]      = s.ctrl.peripheral_protocol_select;
        w[dcs_pkg::BIT_OWN_TERM]   = s.ctrl.own_termination_speed;
        w[dcs_pkg::BIT_SLAVE_TERM] = s.ctrl.slave_termination_speed;
        w[dcs_pkg::BIT_LOCAL_PORT_WIDTH]     = s.ctrl.local_port_width;

        pack_word = w;
    endfunction

    // unpack writable control fields
    function automatic dcs_pkg::dcs_ctrl_t unpack_ctrl(input logic [31:0] w);
        dcs_pkg::dcs_ctrl_t c;

        c.cmd_sel                     = w[dcs_pkg::BIT_CMD_SEL];
        c.fifo_watermark              = w[dcs_pkg::POS_WATERMARK +: 4];
        c.transfer_code_match         = w[dcs_pkg::POS_XFER_CODE +: 4];
        c.transfer_code_decode_enable = w[dcs_pkg::BIT_CODE_EN];
        c.chain                       = w[dcs_pkg::BIT_CHAIN];
        c.engine_dma                  = w[dcs_pkg::BIT_ENGINE];
        c.dir_to_pci                  = w[dcs_pkg::BIT_DIR];
        c.peripheral_protocol_select  = w[dcs_pkg::BIT_PROTO];
        c.own_termination_speed       = w[dcs_pkg::BIT_OWN_TERM];
        c.slave_termination_speed     = w[dcs_pkg::BIT_SLAVE_TERM];
        c.local_port_width            = w[dcs_pkg::BIT_LOCAL_PORT_WIDTH];

        unpack_ctrl = c;
    endfunction

    // write-one-to-clear mask from a write word
    function automatic dcs_pkg::dcs_flags_t w1c(input logic [31:0] w);
        dcs_pkg::dcs_flags_t f;

        f.reset_occurred_flag  = w[dcs_pkg::BIT_RST_FLAG];
        f.finished             = w[dcs_pkg::BIT_FINISHED];
        f.pci_error_flag       = w[dcs_pkg::BIT_PCI_ERR];
        f.local_bus_error_flag = w[dcs_pkg::BIT_LOCAL_ERR];

        w1c = f;
    endfunction

    // ----
    // sub-blocks
    // ----
    // watermark threshold on the inbound queue
    dcs_watermark #(
        .LEVEL_W (LEVEL_W)
    ) u_wm (
        .fifo_watermark     (st_r.ctrl.fifo_watermark),
        .cache_line_setting (cache_line_setting),
        .queued_bytes       (queued_bytes),
        .request_bus        (wm_request)
    );

    // data buffer; emptied when the channel is reset
    dcs_buf2 #(
        .WIDTH (dcs_pkg::BUF_WIDTH)
    ) u_buf (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .flush     (flush),
        .in_valid  (in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (in_data),
        .out_valid (buf_out_valid),
        .out_ready (out_ready),
        .out_data  (buf_out_data)
    );

    assign in_ready  = buf_in_ready;
    assign out_valid = buf_out_valid;
    assign out_data  = buf_out_data;

    // ----
    // next state
    // ----
    always_comb begin
        logic               running;
        logic               wr_any;
        logic [31:0]        wd;
        logic               launch;
        logic               rst_req;
        dcs_pkg::dcs_flags_t clr;
        dcs_pkg::dcs_flags_t set;
        logic               code_ok;

        st_nxt  = st_r;
        running = (st_r.fsm == dcs_pkg::DCS_RUN);
        flush   = 1'b0;

        // local side wins when both buses write the same cycle
        wr_any  = hits(pci_req) || hits(local_req);
        wd      = hits(local_req) ? local_req.wdata : pci_req.wdata;
        launch  = wr_any && wd[dcs_pkg::BIT_LAUNCH];
        rst_req = wr_any && wd[dcs_pkg::BIT_RST_REQ];
        clr     = wr_any ? w1c(wd) : '0;
        set     = '0;
        code_ok = !st_r.ctrl.transfer_code_decode_enable
                  || (transfer_code_in == st_r.ctrl.transfer_code_match);

        // control fields and count writes
        if (wr_any) begin
            st_nxt.ctrl = unpack_ctrl(wd);
        end

        if (count_load_en) begin
            st_nxt.count = count_load;
        end

        // channel sequencer
        case (st_r.fsm)
            dcs_pkg::DCS_IDLE: begin
                if (launch && (st_nxt.count >= dcs_pkg::MIN_COUNT_WORDS)) begin
                    st_nxt.fsm = dcs_pkg::DCS_RUN;
                end
            end

            dcs_pkg::DCS_RUN: begin
                if (rst_req) begin
                    st_nxt.fsm = dcs_pkg::DCS_IDLE;
                    set.reset_occurred_flag = 1'b1;
                    flush = 1'b1;
                end else begin
                    if (pci_word_done) begin
                        st_nxt.count = st_r.count - COUNT_W'(dcs_pkg::WORD_STEP);
                    end
                    if ((pci_word_done && st_r.count == COUNT_W'(dcs_pkg::WORD_STEP))
                        || (peripheral_done && !st_r.ctrl.engine_dma)) begin
                        st_nxt.fsm = dcs_pkg::DCS_FINISH;
                    end
                end

                set.pci_error_flag       = pci_error;
                set.local_bus_error_flag = local_bus_error;
            end

            dcs_pkg::DCS_FINISH: begin
                set.finished = 1'b1;
                st_nxt.fsm   = dcs_pkg::DCS_IDLE;
            end

            default: begin
                st_nxt.fsm = dcs_pkg::DCS_IDLE;
            end
        endcase

        // sticky flags: set wins over clear
        st_nxt.flags = (st_r.flags & ~clr) | set;

        // acknowledge qualification in peripheral mode
        st_nxt.ack_q = running && peripheral_acknowledge
                       && (st_r.ctrl.engine_dma || code_ok);

        // bus request only while running
        st_nxt.req_q = running && wm_request;

        // termination speeds, first family peripheral mode only
        st_nxt.fast_q = !st_r.ctrl.engine_dma && !st_r.ctrl.peripheral_protocol_select
                        && dual_address && st_r.ctrl.own_termination_speed;

        st_nxt.sfast_q = !st_r.ctrl.engine_dma && !st_r.ctrl.peripheral_protocol_select
                         && !dual_address && st_r.ctrl.slave_termination_speed;

        // mode outputs
        st_nxt.mode.pci_cmd = st_r.ctrl.dir_to_pci
            ? (st_r.ctrl.cmd_sel ? dcs_pkg::PCI_CMD_WR_INV : dcs_pkg::PCI_CMD_MEM_WR)
            : (st_r.ctrl.cmd_sel ? dcs_pkg::PCI_CMD_RD_LINE : dcs_pkg::PCI_CMD_MEM_RD);

        st_nxt.mode.linked_list     = st_r.ctrl.chain;
        st_nxt.mode.stand_alone     = st_r.ctrl.engine_dma;
        st_nxt.mode.dir_to_pci      = st_r.ctrl.dir_to_pci;
        st_nxt.mode.proto_second    = st_r.ctrl.peripheral_protocol_select;
        st_nxt.mode.fast_own_term   = st_r.ctrl.own_termination_speed;
        st_nxt.mode.fast_slave_term = st_r.ctrl.slave_termination_speed;
        st_nxt.mode.port_16bit      = st_r.ctrl.local_port_width;

        // read data returned next cycle on each bus
        st_nxt.pci_rdata = (pci_req.rd && pci_req.addr == dcs_pkg::CTRL_STATUS_OFS)
                           ? pack_word(st_r) : 32'h00000000;

        st_nxt.local_rdata = (local_req.rd && local_req.addr == dcs_pkg::CTRL_STATUS_OFS)
                             ? pack_word(st_r) : 32'h00000000;
    end

    // ----
    // state register
    // ----
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----
    // outputs
    // ----
    assign pci_rdata              = st_r.pci_rdata;
    assign local_rdata            = st_r.local_rdata;

    assign transfer_running       = (st_r.fsm == dcs_pkg::DCS_RUN);
    assign ack_qualified          = st_r.ack_q;

    assign pci_bus_request        = st_r.req_q;
    assign fast_termination       = st_r.fast_q;
    assign slave_fast_termination = st_r.sfast_q;

    assign mode                   = st_r.mode;
    assign event_flags            = st_r.flags;
    assign remaining_byte_counter = st_r.count;

endmodule

`default_nettype wire

/* testbench/dcs_checker.sv */
// dcs_checker: port-level checks of the channel control block
// assumes: bound to dcs_channel_ctrl; one clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
module dcs_checker #(
    parameter int COUNT_W = 22
) (
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    input wire dcs_pkg::dcs_reg_req_t pci_req,
    input wire dcs_pkg::dcs_reg_req_t local_req,
    input wire logic [31:0]           pci_rdata,
    input wire logic                  pci_word_done,
    input wire logic                  pci_error,
    input wire logic                  local_bus_error,
    input wire logic                  transfer_running,
    input wire dcs_pkg::dcs_flags_t   event_flags,
    input wire logic [COUNT_W-1:0]    remaining_byte_counter
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // control-word writes, and bus-quiet cycles
    logic               wr, lw, run, quiet;
    logic [31:0]        wd;
    logic [COUNT_W-1:0] cnt;
    assign lw = local_req.wr && local_req.addr == 12'h400;
    assign wr = lw || pci_req.wr && pci_req.addr == 12'h400;
    assign quiet = !pci_req.wr && !local_req.wr;
    assign wd = lw ? local_req.wdata : pci_req.wdata;
    assign run = transfer_running;
    assign cnt = remaining_byte_counter;
    property p_go; wr && wd[31] && !run && !$past(run) && cnt >= 16 |=> run; endproperty
    a_go: assert property (p_go) else $error("launch ignored");
    property p_short; wr && wd[31] && !run && cnt < 16 |=> !run; endproperty
    a_short: assert property (p_short) else $error("short count started");
    property p_rst; wr && wd[30] && run |=> !run && event_flags.reset_occurred_flag; endproperty
    a_rst: assert property (p_rst) else $error("reset request lost");
    property p_idle;
        wr && wd[31:19] == 13'h0800 && !run && !$past(run) |=> $stable(event_flags) && !run;
    endproperty
    a_idle: assert property (p_idle) else $error("idle reset request acted");
    property p_rz; pci_rdata[31:30] == 2'b00; endproperty
    a_rz: assert property (p_rz) else $error("strobe bits read nonzero");
    property p_act; pci_req.rd && pci_req.addr == 12'h400 |=> pci_rdata[23] == $past(run); endproperty
    a_act: assert property (p_act) else $error("running bit wrong");
    property p_pe; pci_error && run |=> event_flags.pci_error_flag; endproperty
    a_pe: assert property (p_pe) else $error("pci error not flagged");
    property p_le; local_bus_error && run |=> event_flags.local_bus_error_flag; endproperty
    a_le: assert property (p_le) else $error("local error not flagged");
    property p_dec; run && pci_word_done && quiet && cnt > 1 |=> cnt == $past(cnt) - 1'b1; endproperty
    a_dec: assert property (p_dec) else $error("counter step wrong");
    property p_fin; run && pci_word_done && quiet && cnt == 1 |=> !run ##1 event_flags.finished;
    endproperty
    a_fin: assert property (p_fin) else $error("expiry not finished");
endmodule
bind dcs_channel_ctrl dcs_checker #(.COUNT_W(COUNT_W)) dcs_checker_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .pci_req(pci_req), .local_req(local_req),
    .pci_rdata(pci_rdata), .pci_word_done(pci_word_done), .pci_error(pci_error),
    .local_bus_error(local_bus_error), .transfer_running(transfer_running),
    .event_flags(event_flags), .remaining_byte_counter(remaining_byte_counter));
`default_nettype wire

/* testbench/dcs_far_end.sv */
// dcs_far_end: pci-side model draining the channel buffer
// assumes: bench clock; hold stalls it fully, otherwise it stalls at random
`timescale 1ns/1ps
`default_nettype none
module dcs_far_end (
    input  wire logic sys_clk,
    input  wire logic out_valid,
    input  wire logic running,
    input  wire logic hold,
    output logic      out_ready,
    output logic      pci_word_done
);
    integer seed = 28;
    // accept words at a random rate, never while held
    initial out_ready = 1'b0;
    always @(negedge sys_clk) out_ready = !hold && ($random(seed) % 4 != 0);
    // one pci word completes with each accepted word while the channel is running
    assign pci_word_done = out_valid && out_ready && running;
endmodule
`default_nettype wire

/* testbench/tb.sv */
// tb: self-checking bench for the channel control block
// assumes: dcs_pkg, design, checker and far-end model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                  sys_clk = 0, rst_n = 0, hold = 1, rd_d = 0, rs_d = 0;
    dcs_pkg::dcs_reg_req_t preq = '0, lreq = '0;
    logic [31:0]           pci_rdata, local_rdata, in_data = 0, out_data, d;
    logic [21:0]           count_load = 0, cnt;
    logic                  ld = 0, pdone = 0, perr = 0, lerr = 0, in_valid = 0, ack = 0;
    logic [3:0]            tcode = 0;
    logic [8:0]            qb = 0;
    logic                  in_ready, out_valid, out_ready, wdone, run, ack_q, breq;
    dcs_pkg::dcs_mode_t    mode;
    dcs_pkg::dcs_flags_t   flags;
    logic [31:0]           exp_rd[$], exp_dat[$];
    int                    n_mismatch = 0, n_compared = 0, cyc = 0;
    integer                seed = 28;
    // 250 MHz clock
    initial forever #2 sys_clk = ~sys_clk;
    dcs_channel_ctrl dcs_channel_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .pci_req(preq),
        .local_req(lreq), .pci_rdata(pci_rdata), .local_rdata(local_rdata),
        .count_load(count_load), .count_load_en(ld), .pci_word_done(wdone),
        .peripheral_done(pdone), .pci_error(perr), .local_bus_error(lerr),
        .transfer_code_in(tcode), .peripheral_acknowledge(ack), .dual_address(1'b0),
        .cache_line_setting(2'b00), .queued_bytes(qb), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .transfer_running(run), .ack_qualified(ack_q),
        .pci_bus_request(breq), .fast_termination(), .slave_fast_termination(),
        .mode(mode), .event_flags(flags), .remaining_byte_counter(cnt));
    dcs_far_end dcs_far_end_inst (.sys_clk(sys_clk), .out_valid(out_valid), .running(run),
        .hold(hold), .out_ready(out_ready), .pci_word_done(wdone));
    task stop_test();
        if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task acc(input logic s, input logic w, input logic [11:0] a, input logic [31:0] v);
        @(negedge sys_clk);
        if (s) lreq = '{w, !w, a, v};
        else preq = '{w, !w, a, v};
        @(negedge sys_clk);
        lreq = '0;
        preq = '0;
    endtask
    task rd(input logic s, input logic [11:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        acc(s, 1'b0, a, 32'h0);
    endtask
    task load(input logic [21:0] v);
        @(negedge sys_clk) {count_load, ld} = {v, 1'b1};
        @(negedge sys_clk) ld = 1'b0;
    endtask
    task push(input int n);
        @(negedge sys_clk);
        repeat (n) begin
            in_data = $random(seed);
            in_valid = 1'b1;
            exp_dat.push_back(in_data);
            while (!in_ready) @(negedge sys_clk);
            @(negedge sys_clk);
        end
        in_valid = 1'b0;
    endtask
    // monitor: read answers, drained words, timeout
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (rd_d) cmp(rs_d ? local_rdata : pci_rdata, exp_rd.pop_front());
        rd_d <= preq.rd || lreq.rd;
        rs_d <= lreq.rd;
        if (out_valid && out_ready) cmp(out_data, exp_dat.pop_front());
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // main sequence
    initial begin
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        rd(0, 12'h400, 32'h0);
        rd(1, 12'h404, 32'h0);
        repeat (4) begin
            d = $random(seed) & 32'h0004_0FFF | 32'h0000_1000;
            acc(1, 1, 12'h400, d);
            rd(0, 12'h400, d);
            cmp(mode.pci_cmd, {d[18], 2'b11, d[4]});
            cmp({mode.linked_list, mode.stand_alone, mode.dir_to_pci}, d[6:4]);
        end
        load(22'h00000F);
        acc(0, 1, 12'h400, 32'h8000_1000);
        cmp(run, 0);
        load(22'h000010);
        hold = 1'b0;
        acc(1, 1, 12'h400, 32'h8000_1000);
        cmp(run, 1);
        rd(0, 12'h400, 32'h0080_1000);
        @(negedge sys_clk) qb = 9'd15;
        @(negedge sys_clk) cmp(breq, 0);
        @(negedge sys_clk) qb = 9'd16;
        @(negedge sys_clk) cmp(breq, 1);
        push(16);
        while (run) @(negedge sys_clk);
        @(negedge sys_clk) cmp(flags.finished, 1);
        cmp({out_valid, cnt}, 0);
        acc(0, 1, 12'h404, 32'hFFFF_FFFF);
        acc(0, 1, 12'h400, 32'h0000_1000);
        rd(0, 12'h400, 32'h0020_1000);
        acc(0, 1, 12'h400, 32'h0020_1000);
        rd(1, 12'h400, 32'h0000_1000);
        hold = 1'b1;
        load(22'h000010);
        acc(0, 1, 12'h400, 32'h8000_0000);
        push(2);
        cmp(in_ready, 0);
        @(negedge sys_clk) {perr, lerr} = 2'b11;
        @(negedge sys_clk) {perr, lerr} = 2'b00;
        acc(1, 1, 12'h400, 32'h4000_0000);
        exp_dat.delete();
        cmp({run, out_valid}, 0);
        rd(1, 12'h400, 32'h0058_0000);
        acc(0, 1, 12'h400, 32'h4000_0000);
        rd(0, 12'h400, 32'h0058_0000);
        acc(0, 1, 12'h400, 32'h0078_0000);
        cmp(flags, 0);
        load(22'h000010);
        acc(0, 1, 12'h400, 32'h8000_1580);
        @(negedge sys_clk) {tcode, ack} = 5'h0B;
        @(negedge sys_clk) cmp(ack_q, 1);
        @(negedge sys_clk) tcode = 4'h3;
        @(negedge sys_clk) cmp(ack_q, 0);
        @(negedge sys_clk) {pdone, ack} = 2'b10;
        @(negedge sys_clk) pdone = 1'b0;
        @(negedge sys_clk) cmp({run, flags.finished}, 1);
        stop_test();
    end
endmodule
`default_nettype wire
